// ### src/ulrd_params.svh
/*
  Register map, field positions and reset values of the line resistor decoder.
  Assumes a 32-bit Avalon-MM slave with byte addresses.
*/
`ifndef ULRD_PARAMS_SVH
`define ULRD_PARAMS_SVH
`define ULRD_ADDR_W      4
`define ULRD_DATA_W      32
`define ULRD_OFS_CTRL    4'h0
`define ULRD_OFS_STAT    4'h4
`define ULRD_CTRL_SPD_LO 0
`define ULRD_CTRL_SPD_HI 1
`define ULRD_CTRL_TERM   2
`define ULRD_CTRL_OPM_LO 3
`define ULRD_CTRL_OPM_HI 4
`define ULRD_CTRL_DPREQ  5
`define ULRD_CTRL_DMREQ  6
`define ULRD_CTRL_W      7
`define ULRD_CTRL_RST    7'h61
`define ULRD_STAT_W      8
`endif

// ### src/ulrd_pkg.sv
/*
  Types shared by the line resistor decoder files.
  Assumes the constants of ulrd_params.svh.
*/
package ulrd_pkg;
  typedef enum logic [1:0] {
    ULRD_CLS_OFF    = 2'h0,
    ULRD_CLS_HOST   = 2'h1,
    ULRD_CLS_OTG    = 2'h3,
    ULRD_CLS_PERIPH = 2'h2
  } ulrd_class_t;
endpackage : ulrd_pkg

// ### src/ulrd_reg_if.sv
/*
  Internal register access strobes between bus slave and register core.
  Assumes one clock; strobes are one-cycle pulses.
*/
`timescale 1ns/1ps
`include "ulrd_params.svh"
interface ulrd_reg_if;
  logic                    wr_stb;
  logic [`ULRD_ADDR_W-1:0] addr;
  logic [`ULRD_DATA_W-1:0] wdata;
  logic [3:0]              be;
  logic [`ULRD_DATA_W-1:0] rdata;
  modport bus
  (
    output wr_stb, addr, wdata, be,
    input  rdata
  );
  modport core
  (
    input  wr_stb, addr, wdata, be,
    output rdata
  );
endinterface : ulrd_reg_if

// ### src/ulrd_avmm.sv
/*
  Avalon-MM slave front end with one fixed wait state per access.
  Assumes a master that holds its request until waitrequest is low.
*/
`timescale 1ns/1ps
`include "ulrd_params.svh"
module ulrd_avmm
  import ulrd_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk_in,
  input  wire logic                    rst_in,
  // Avalon-MM
  input  wire logic [`ULRD_ADDR_W-1:0] avs_address_in,
  input  wire logic                    avs_read_in,
  input  wire logic                    avs_write_in,
  input  wire logic [`ULRD_DATA_W-1:0] avs_writedata_in,
  input  wire logic [3:0]              avs_byteenable_in,
  output logic      [`ULRD_DATA_W-1:0] avs_readdata_out,
  output logic                         avs_waitrequest_out,
  // Register core
  ulrd_reg_if.bus                      regs
);
  logic ack_q;
  logic req;
  assign req = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~ack_q;
  assign regs.wr_stb = avs_write_in & ack_q;
  assign regs.addr = avs_address_in;
  assign regs.wdata = avs_writedata_in;
  assign regs.be = avs_byteenable_in;
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ack_q            <= 1'b0;
      avs_readdata_out <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= req & ~ack_q;
      if (avs_read_in & ~ack_q)
        avs_readdata_out <= regs.rdata;
    end
  end
endmodule : ulrd_avmm

// ### src/ulrd_decode.sv
/*
  Enable equations for the internal line resistors, registered.
  Assumes field inputs from the control register of the same clock.
*/
`timescale 1ns/1ps
module ulrd_decode
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Control fields
  input  wire logic [1:0] speed_sel_in,
  input  wire logic       term_in,
  input  wire logic [1:0] opsel_in,
  input  wire logic       dp_req_in,
  input  wire logic       dm_req_in,
  // Resistor enables
  output logic            dp_pullup_on_out,
  output logic            dp_pulldn_on_out,
  output logic            dm_pulldn_on_out,
  output logic            hsterm_on_out
);
  logic drivers_off;
  assign drivers_off = (opsel_in == 2'h1);
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      dp_pullup_on_out <= 1'b0;
      dp_pulldn_on_out <= 1'b0;
      dm_pulldn_on_out <= 1'b0;
      hsterm_on_out    <= 1'b0;
    end
    else
    begin
      dp_pullup_on_out <= ~drivers_off & term_in & ~dp_req_in;
      dp_pulldn_on_out <= ~drivers_off & dp_req_in;
      dm_pulldn_on_out <= ~drivers_off & dm_req_in;
      hsterm_on_out    <= ~drivers_off & (speed_sel_in == 2'h0) & ~term_in;
    end
  end
endmodule : ulrd_decode

// ### src/usb_line_resistor_decoder.sv
/*
  Line resistor decoder: control fields written over Avalon-MM are decoded
  into enables for the DP pull-up, DP and DM pull-downs and the high-speed
  terminations; a status word reports enables and the decoded state class.
  Assumes the link programs the fields; the analog front end follows
  the four enable outputs.
*/
`timescale 1ns/1ps
`include "ulrd_params.svh"
module usb_line_resistor_decoder
  import ulrd_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk_in,
  input  wire logic                    rst_in,
  // Avalon-MM register slave
  input  wire logic [`ULRD_ADDR_W-1:0] avs_address_in,
  input  wire logic                    avs_read_in,
  input  wire logic                    avs_write_in,
  input  wire logic [`ULRD_DATA_W-1:0] avs_writedata_in,
  input  wire logic [3:0]              avs_byteenable_in,
  output logic      [`ULRD_DATA_W-1:0] avs_readdata_out,
  output logic                         avs_waitrequest_out,
  // Resistor enables to the analog front end
  output logic                         dp_pullup_on_out,
  output logic                         dp_pulldn_on_out,
  output logic                         dm_pulldn_on_out,
  output logic                         highspeed_termination_on_out
);
  ulrd_reg_if regs ();

  ulrd_avmm u_avmm
  (
    .clk_in              (clk_in),
    .rst_in              (rst_in),
    .avs_address_in      (avs_address_in),
    .avs_read_in         (avs_read_in),
    .avs_write_in        (avs_write_in),
    .avs_writedata_in    (avs_writedata_in),
    .avs_byteenable_in   (avs_byteenable_in),
    .avs_readdata_out    (avs_readdata_out),
    .avs_waitrequest_out (avs_waitrequest_out),
    .regs                (regs)
  );

  // Control register
  logic [`ULRD_CTRL_W-1:0] ctrl_q;
  logic [`ULRD_CTRL_W-1:0] ctrl_d;
  logic                    ctrl_sel;
  logic                    stat_sel;
  logic                    ctrl_wr;

  assign ctrl_sel = (regs.addr == `ULRD_OFS_CTRL);
  assign stat_sel = (regs.addr == `ULRD_OFS_STAT);
  assign ctrl_wr = regs.wr_stb & ctrl_sel & regs.be[0];
  assign ctrl_d = ctrl_wr ? regs.wdata[`ULRD_CTRL_W-1:0] : ctrl_q;

  // fields only change by link writes
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      ctrl_q <= `ULRD_CTRL_RST;
    else
      ctrl_q <= ctrl_d;
  end

  // Field views
  logic [1:0] transceiver_speed_sel;
  logic       termination_choice;
  logic [1:0] operating_select;
  logic       dp_low_request;
  logic       dm_low_request;

  assign transceiver_speed_sel =
    ctrl_q[`ULRD_CTRL_SPD_HI:`ULRD_CTRL_SPD_LO];
  assign termination_choice = ctrl_q[`ULRD_CTRL_TERM];
  assign operating_select = ctrl_q[`ULRD_CTRL_OPM_HI:`ULRD_CTRL_OPM_LO];
  assign dp_low_request = ctrl_q[`ULRD_CTRL_DPREQ];
  assign dm_low_request = ctrl_q[`ULRD_CTRL_DMREQ];

  ulrd_decode u_decode
  (
    .clk_in           (clk_in),
    .rst_in           (rst_in),
    .speed_sel_in     (transceiver_speed_sel),
    .term_in          (termination_choice),
    .opsel_in         (operating_select),
    .dp_req_in        (dp_low_request),
    .dm_req_in        (dm_low_request),
    .dp_pullup_on_out (dp_pullup_on_out),
    .dp_pulldn_on_out (dp_pulldn_on_out),
    .dm_pulldn_on_out (dm_pulldn_on_out),
    .hsterm_on_out    (highspeed_termination_on_out)
  );

  // State classification for status
  logic        mode_off;
  logic        mode_norm;
  logic        mode_chirp;
  logic        spd_hs;
  logic        spd_fs;
  logic        spd_ls;
  logic        hs_set;
  logic        pchirp_set;
  logic        fsr_set;
  logic        host_ok;
  logic        dev_ok;
  logic        pwrup_ok;
  logic        listed;
  ulrd_class_t state_class;

  assign mode_off = (operating_select == 2'h1);
  assign mode_norm = (operating_select == 2'h0);
  assign mode_chirp = (operating_select == 2'h2);
  assign spd_hs = (transceiver_speed_sel == 2'h0);
  assign spd_fs = (transceiver_speed_sel == 2'h1);
  assign spd_ls = (transceiver_speed_sel == 2'h2);
  assign hs_set = spd_hs & ~termination_choice & (mode_norm | mode_chirp);
  assign pchirp_set = spd_hs & termination_choice & mode_chirp;
  assign fsr_set = spd_fs & termination_choice & (mode_norm | mode_chirp);
  // speed X1b, 01b or 10b accepted
  assign host_ok = hs_set | (termination_choice & mode_norm &
                   (transceiver_speed_sel[0] | spd_ls)) |
                   (termination_choice & mode_chirp & (spd_fs | spd_ls));
  assign dev_ok = hs_set | pchirp_set | fsr_set;
  assign pwrup_ok = spd_fs & ~termination_choice & mode_norm;

  assign listed = mode_off |
                  (dp_low_request & dm_low_request & (host_ok | pwrup_ok)) |
                  (~dp_low_request & dev_ok);

  assign state_class = mode_off ? ULRD_CLS_OFF :
                       (dp_low_request ? ULRD_CLS_HOST :
                       (dm_low_request ? ULRD_CLS_OTG : ULRD_CLS_PERIPH));

  // Status word and read mux
  logic [`ULRD_STAT_W-1:0] stat_word;

  assign stat_word = {mode_off, ~listed, state_class,
                      highspeed_termination_on_out, dm_pulldn_on_out,
                      dp_pulldn_on_out, dp_pullup_on_out};

  assign regs.rdata = ctrl_sel ?
                      {{(`ULRD_DATA_W-`ULRD_CTRL_W){1'b0}}, ctrl_q} :
                      (stat_sel ?
                      {{(`ULRD_DATA_W-`ULRD_STAT_W){1'b0}}, stat_word} :
                      32'h0000_0000);

  // Assertions
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  logic past_ok_q;
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      past_ok_q <= 1'b0;
    else
      past_ok_q <= 1'b1;
  end

  sequence s_ctrl_is(logic [6:0] v);
    past_ok_q && (ctrl_q == v);
  endsequence

  sequence s_outs(logic pu, logic dpd, logic dmd, logic ht);
    (dp_pullup_on_out == pu) && (dp_pulldn_on_out == dpd) &&
    (dm_pulldn_on_out == dmd) && (highspeed_termination_on_out == ht);
  endsequence

  sequence s_bus_access;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence

  sequence s_read_wait;
    avs_read_in && avs_waitrequest_out;
  endsequence

  sequence s_write_done;
    avs_write_in && !avs_waitrequest_out;
  endsequence

  a_outs_follow_fields: assert property (
    past_ok_q |=> s_outs(
      $past(termination_choice) && !$past(dp_low_request) &&
        ($past(operating_select) != 2'h1),
      $past(dp_low_request) && ($past(operating_select) != 2'h1),
      $past(dm_low_request) && ($past(operating_select) != 2'h1),
      ($past(transceiver_speed_sel) == 2'h0) && !$past(termination_choice)
        && ($past(operating_select) != 2'h1)))
    else $error("enables do not match the control fields");

  a_pullup_only_term: assert property (
    dp_pullup_on_out |-> $past(termination_choice) && !$past(dp_low_request))
    else $error("pull-up on without term select");

  a_dp_pulldn_req: assert property (
    dp_pulldn_on_out |-> $past(dp_low_request))
    else $error("DP pull-down on without request");

  a_dm_pulldn_req: assert property (
    dm_pulldn_on_out |-> $past(dm_low_request))
    else $error("DM pull-down on without request");

  a_hsterm_speed_sel: assert property (
    highspeed_termination_on_out |->
      ($past(transceiver_speed_sel) == 2'h0) && !$past(termination_choice))
    else $error("terminations on outside high-speed select");

  a_ctrl_only_write: assert property (
    !ctrl_wr |=> $stable(ctrl_q))
    else $error("control changed without a write");

  a_mode_off_all: assert property (
    past_ok_q && mode_off |=> s_outs(1'b0, 1'b0, 1'b0, 1'b0))
    else $error("mode 01b left an enable on");

  a_powerup_state: assert property (
    s_ctrl_is(7'h61) |=> s_outs(1'b0, 1'b1, 1'b1, 1'b0))
    else $error("power-up setting decoded wrong");

  a_host_chirp_hs: assert property (
    past_ok_q && dp_low_request && dm_low_request && hs_set
      |=> s_outs(1'b0, 1'b1, 1'b1, 1'b1))
    else $error("host high-speed state decoded wrong");

  a_host_fs_ls: assert property (
    s_ctrl_is(7'h67) or s_ctrl_is(7'h66) or s_ctrl_is(7'h65)
      |=> s_outs(1'b0, 1'b1, 1'b1, 1'b0))
    else $error("host full or low speed decoded wrong");

  a_host_resume: assert property (
    s_ctrl_is(7'h75) or s_ctrl_is(7'h76)
      |=> s_outs(1'b0, 1'b1, 1'b1, 1'b0))
    else $error("host resume decoded wrong");

  a_periph_no_req: assert property (
    past_ok_q && !dp_low_request && !dm_low_request && !mode_off
      |=> s_outs($past(termination_choice), 1'b0, 1'b0,
                 $past(hs_set) || ($past(spd_hs) &&
                 !$past(termination_choice))))
    else $error("peripheral state decoded wrong");

  a_otg_chirp: assert property (
    s_ctrl_is(7'h54) |=> s_outs(1'b1, 1'b0, 1'b1, 1'b0))
    else $error("OTG chirp decoded wrong");

  a_otg_dm_kept: assert property (
    past_ok_q && (state_class == ULRD_CLS_OTG)
      |=> dm_pulldn_on_out && !dp_pulldn_on_out
          && (dp_pullup_on_out != highspeed_termination_on_out
              || !$past(listed)))
    else $error("OTG state lost DM pull-down");

  a_pullup_term_excl: assert property (
    !(dp_pullup_on_out && highspeed_termination_on_out))
    else $error("pull-up and terminations both on");

  a_unlisted_flag: assert property (
    past_ok_q && !listed && (operating_select == 2'h3)
      |=> s_outs($past(termination_choice) && !$past(dp_low_request),
                 $past(dp_low_request), $past(dm_low_request),
                 $past(spd_hs) && !$past(termination_choice)))
    else $error("unlisted combination not decoded");

  a_bus_one_wait: assert property (
    s_bus_access |=> !avs_waitrequest_out)
    else $error("waitrequest held more than one cycle");

  a_write_lands: assert property (
    ctrl_wr |=> (ctrl_q == $past(regs.wdata[`ULRD_CTRL_W-1:0])) ##1
      s_outs(termination_choice && !dp_low_request && !mode_off,
             dp_low_request && !mode_off, dm_low_request && !mode_off,
             spd_hs && !termination_choice && !mode_off))
    else $error("control write not stored");

  // Bus write to control lands
  a_bus_write_ctrl: assert property (
    s_write_done ##0 ((avs_address_in == `ULRD_OFS_CTRL) && avs_byteenable_in[0])
      |=> (ctrl_q == $past(avs_writedata_in[`ULRD_CTRL_W-1:0])))
    else $error("bus write to control not stored");

  // Other addresses leave control
  a_ro_other_addr: assert property (
    s_write_done ##0 (avs_address_in != `ULRD_OFS_CTRL) |=> $stable(ctrl_q))
    else $error("write elsewhere changed control");

  // Byte 0 disabled leaves control
  a_be_gate: assert property (
    s_write_done ##0 !avs_byteenable_in[0] |=> $stable(ctrl_q))
    else $error("write without byte 0 changed control");

  // Control reads back
  a_ctrl_readback: assert property (
    s_read_wait ##0 ctrl_sel |=>
      (avs_readdata_out == {{(`ULRD_DATA_W-`ULRD_CTRL_W){1'b0}}, $past(ctrl_q)}))
    else $error("control readback differs");

  // Unmapped reads return zero
  a_unmapped_zero: assert property (
    s_read_wait ##0 (!ctrl_sel && !stat_sel) |=> (avs_readdata_out == 32'h0000_0000))
    else $error("unmapped read returned data");

  // Completion follows one wait cycle
  a_done_after_wait: assert property (
    (avs_read_in || avs_write_in) && !avs_waitrequest_out |-> $past(avs_waitrequest_out))
    else $error("access completed without a wait cycle");

  a_mode3_unlisted: assert property (
    (operating_select == 2'h3) |-> !listed)
    else $error("mode 11b flagged as listed");

  a_reset_powerup: assert property (
    $rose(past_ok_q) |-> s_ctrl_is(7'h61) ##0 s_outs(1'b0, 1'b1, 1'b1, 1'b0))
    else $error("reset did not give the power-up setting");

endmodule : usb_line_resistor_decoder

// ### src/ulrd_unused_placeholder_removed.sv
/*
  Intentionally empty compilation unit.
  Assumes nothing.
*/
`timescale 1ns/1ps

// ### bench/ulrd_link_model.sv
/*
  Link-side bus master model that programs the control fields.
  Assumes the decoder's Avalon-MM slave on the same clock.
*/
`timescale 1ns/1ps
module ulrd_link_model
(
  // Clock
  input  wire logic        clk_in,
  // Avalon-MM master
  output logic      [3:0]  address_out,
  output logic             read_out,
  output logic             write_out,
  output logic      [31:0] writedata_out,
  output logic      [3:0]  byteenable_out,
  input  wire logic [31:0] readdata_in,
  input  wire logic        waitrequest_in
);
  initial
  begin
    address_out    = 4'h0;
    read_out       = 1'b0;
    write_out      = 1'b0;
    writedata_out  = 32'h0000_0000;
    byteenable_out = 4'h0;
  end

  task automatic access(input logic rd, input logic [3:0] a, input logic [31:0] d,
                        input logic [3:0] be, output logic [31:0] q);
    @(posedge clk_in);
    address_out    <= a;
    read_out       <= rd;
    write_out      <= ~rd;
    writedata_out  <= d;
    byteenable_out <= be;
    @(posedge clk_in);
    while (waitrequest_in !== 1'b0)
      @(posedge clk_in);
    q = readdata_in;
    // Idle lines carry junk so stale values are never trusted
    address_out    <= ~a;
    read_out       <= 1'b0;
    write_out      <= 1'b0;
    writedata_out  <= ~d;
    byteenable_out <= ~be;
  endtask : access
endmodule : ulrd_link_model

// ### bench/usb_line_resistor_decoder_tb_top.sv
/*
  Self-checking bench of the line resistor decoder.
  Assumes the link model drives the register bus.
*/
`timescale 1ns/1ps
module usb_line_resistor_decoder_tb_top;
  logic        clk_in;
  logic        rst_in;
  logic [3:0]  address;
  logic        read;
  logic        write;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic [31:0] rdata;
  logic        wait_req;
  logic        pu;
  logic        dp_pd;
  logic        dm_pd;
  logic        hs;
  wire  [3:0]  en_w = {hs, dm_pd, dp_pd, pu};
  int          miscompares;
  int          check_count;
  int          cycles;
  int          seed;
  logic [6:0]  ctrl_q;
  logic [31:0] q;
  logic [31:0] r;
  logic [31:0] wd;
  logic [3:0]  a;
  logic [11:0] states [19] = '{12'h6F0, 12'h616, 12'h70E, 12'h60E, 12'h676, 12'h656,
    12'h756, 12'h666, 12'h766, 12'h141, 12'h008, 12'h051, 12'h151, 12'h108, 12'h545,
    12'h40C, 12'h455, 12'h555, 12'h50C};

  usb_line_resistor_decoder i_dut
  (
    .clk_in                       (clk_in),
    .rst_in                       (rst_in),
    .avs_address_in               (address),
    .avs_read_in                  (read),
    .avs_write_in                 (write),
    .avs_writedata_in             (wdata),
    .avs_byteenable_in            (be),
    .avs_readdata_out             (rdata),
    .avs_waitrequest_out          (wait_req),
    .dp_pullup_on_out             (pu),
    .dp_pulldn_on_out             (dp_pd),
    .dm_pulldn_on_out             (dm_pd),
    .highspeed_termination_on_out (hs)
  );

  ulrd_link_model i_link
  (
    .clk_in         (clk_in),
    .address_out    (address),
    .read_out       (read),
    .write_out      (write),
    .writedata_out  (wdata),
    .byteenable_out (be),
    .readdata_in    (rdata),
    .waitrequest_in (wait_req)
  );

  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  function automatic logic [3:0] exp_en(input logic [6:0] c);
    logic off;
    off       = (c[4:3] == 2'b01);
    exp_en[0] = ~off & c[2] & ~c[5];
    exp_en[1] = ~off & c[5];
    exp_en[2] = ~off & c[6];
    exp_en[3] = ~off & (c[1:0] == 2'b00) & ~c[2];
  endfunction : exp_en

  // listed means a table row or mode 01b
  function automatic logic [7:0] exp_stat(input logic [6:0] c, input logic [3:0] e);
    logic       off;
    logic       hit;
    logic [1:0] cls;
    off = (c[4:3] == 2'b01);
    hit = off;
    foreach (states[k])
      if (states[k][10:4] == c)
        hit = 1'b1;
    cls = off ? 2'h0 : (c[5] ? 2'h1 : (c[6] ? 2'h3 : 2'h2));
    exp_stat = {off, ~hit, cls, e};
  endfunction : exp_stat

  task automatic summarize();
    $display("Counts: %0d checks, %0d mismatches", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("FAIL %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Enables one edge after CTRL changes, then status and readback
  task automatic expect_all(input logic [6:0] c, input logic [3:0] e);
    logic [31:0] v;
    @(posedge clk_in);
    #1;
    chk({28'h0, en_w}, {28'h0, e}, "enables");
    i_link.access(1'b1, 4'h4, 32'h0000_0000, 4'hF, v);
    chk(v, {24'h0, exp_stat(c, e)}, "status");
    i_link.access(1'b1, 4'h0, 32'h0000_0000, 4'hF, v);
    chk(v, {25'h0, c}, "ctrl readback");
  endtask : expect_all

  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 8000)
    begin
      miscompares++;
      $display("FAIL %0t timeout", $time);
      summarize();
    end
  end

  initial
  begin
    rst_in = 1'b1;
    seed   = 90;
    cycles = 0;
    ctrl_q = 7'h61;
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    expect_all(ctrl_q, 4'h6);
    $display("test reset done");
    foreach (states[k])
    begin
      ctrl_q = states[k][10:4];
      i_link.access(1'b0, 4'h0, {25'h0, ctrl_q}, 4'hF, q);
      expect_all(ctrl_q, states[k][3:0]);
    end
    $display("test state table done");
    i_link.access(1'b0, 4'h4, 32'hFFFF_FFFF, 4'hF, q);
    i_link.access(1'b0, 4'h8, 32'hFFFF_FFFF, 4'hF, q);
    i_link.access(1'b0, 4'h0, 32'h0000_0000, 4'hE, q);
    expect_all(ctrl_q, exp_en(ctrl_q));
    i_link.access(1'b1, 4'hC, 32'h0000_0000, 4'hF, q);
    chk(q, 32'h0000_0000, "unmapped read");
    i_link.access(1'b1, 4'h8, 32'h0000_0000, 4'hF, q);
    chk(q, 32'h0000_0000, "unmapped read 8");
    $display("test refused writes done");
    for (int i = 0; i < 60; i++)
    begin
      r  = $random(seed);
      wd = $random(seed);
      a  = r[1] ? 4'h0 : {r[3:2], 2'b00};
      i_link.access(1'b0, a, wd, r[4] ? 4'hF : r[7:4], q);
      // only CTRL with byte 0 enabled takes the word
      if (a == 4'h0 && r[4])
        ctrl_q = wd[6:0];
      expect_all(ctrl_q, exp_en(ctrl_q));
    end
    $display("test random fields done");
    @(posedge clk_in);
    rst_in <= 1'b1;
    #1;
    chk({28'h0, en_w}, 32'h0000_0000, "enables in reset");
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    ctrl_q = 7'h61;
    expect_all(ctrl_q, 4'h6);
    $display("test second reset done");
    summarize();
  end
endmodule : usb_line_resistor_decoder_tb_top
